//--- core/stl1_pkg.sv
// Package with codes, states, timing and carriers of the layer-1 activation block
package stl1_pkg;
    // ------------------------------------------------------------
    // Command and indication codes
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_TIM = 4'h0;
    localparam logic [3:0] CMD_RES = 4'h1;
    localparam logic [3:0] CMD_SSP = 4'h2;
    localparam logic [3:0] CMD_SCP = 4'h3;
    localparam logic [3:0] CMD_AR8 = 4'h8;
    localparam logic [3:0] CMD_ACTIVATION_REQUEST_PRIO10 = 4'h9;
    localparam logic [3:0] CMD_ARL = 4'hA;
    localparam logic [3:0] CMD_DI = 4'hF;
    localparam logic [3:0] IND_DR = 4'h0;
    localparam logic [3:0] IND_RES = 4'h1;
    localparam logic [3:0] IND_TMA = 4'h2;
    localparam logic [3:0] IND_RSY = 4'h4;
    localparam logic [3:0] IND_DR6 = 4'h5;
    localparam logic [3:0] IND_PU = 4'h7;
    localparam logic [3:0] IND_AR = 4'h8;
    localparam logic [3:0] IND_ARL = 4'hA;
    localparam logic [3:0] IND_AI8 = 4'hC;
    localparam logic [3:0] IND_AI10 = 4'hD;
    localparam logic [3:0] IND_AIL = 4'hE;
    localparam logic [3:0] IND_DC = 4'hF;
    localparam logic [7:0] INFO1_PATTERN = 8'h3F;
    // ------------------------------------------------------------
    // Register offsets and fields
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_CI_TX = 4'h1;
    localparam logic [3:0] ADDR_CI_RX = 4'h2;
    localparam logic [3:0] ADDR_SW_CMD = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_INT = 4'h5;
    localparam int CFG_SWCTL_BIT = 0;
    localparam int CFG_CFS_BIT = 1;
    localparam int CFG_TXDIS_BIT = 2;
    localparam int CFG_INTLOOP_BIT = 3;
    localparam int CFG_PWRDN_BIT = 4;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [3:0] CI_TX_RESET = 4'h1;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_STOP_US = 500;
    localparam int CLK_STOP_CYC = (CLK_STOP_US * (CLK_HZ / 1_000_000));
    localparam int SSP_HZ = 2_000;
    localparam int SCP_HZ = 96_000;
    localparam int SSP_HALF_CYC = CLK_HZ / (2 * SSP_HZ);
    localparam int SCP_HALF_CYC = CLK_HZ / (2 * SCP_HZ);
    localparam int OSC_DIV = 2;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_F3_PEND_DEACT = 4'h1,
        ST_F3_DEACT = 4'h2,
        ST_F3_PWRUP = 4'h3,
        ST_F4_PEND_ACT = 4'h4,
        ST_F5_UNSYNC = 4'h5,
        ST_F6_SYNC = 4'h6,
        ST_F7_ACT = 4'h7,
        ST_F8_LOST = 4'h8,
        ST_LOOP_CLOSED = 4'h9,
        ST_LOOP_ACT = 4'hA,
        ST_TEST_SSP = 4'hB,
        ST_TEST_SCP = 4'hC
    } stl1_state_e;
    typedef enum logic [2:0] {
        TX_INFO0 = 3'h0,
        TX_INFO1 = 3'h1,
        TX_INFO3 = 3'h3,
        TX_TEST1 = 3'h4,
        TX_TEST2 = 3'h5
    } stl1_txinfo_e;
    // Receiver view of the line
    typedef struct packed {
        logic info0;
        logic info2;
        logic info4;
        logic sync;
        logic awake;
    } stl1_rx_s;
endpackage : stl1_pkg

//--- core/stl1_pulse_gen.sv
// Line pattern generator for info 1 and the two pulse test modes
module stl1_pulse_gen #(
    parameter int SSP_HALF = stl1_pkg::SSP_HALF_CYC,
    parameter int SCP_HALF = stl1_pkg::SCP_HALF_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire stl1_pkg::stl1_txinfo_e tx_info,
    output logic line_bit,
    output logic pulse_pos,
    output logic pulse_neg
);
    // ------------------------------------------------------------
    // Half period counter and bit index
    // ------------------------------------------------------------
    logic [15:0] cnt;
    logic [2:0] bit_idx;
    logic pol;
    wire is_ssp = (tx_info == stl1_pkg::TX_TEST1);
    wire is_scp = (tx_info == stl1_pkg::TX_TEST2);
    wire [15:0] half = is_ssp ? 16'(SSP_HALF) : 16'(SCP_HALF);
    wire half_done = (cnt >= half - 16'h0001);
    wire next_line_bit = stl1_pkg::INFO1_PATTERN[3'h7 - bit_idx];

    // Info 1 cycles through the pattern; tests alternate polarity
    always_ff @(posedge clk) begin
        if (srst || !(is_ssp || is_scp)) begin
            cnt <= 16'h0000;
            pol <= 1'b0;
        end else if (half_done) begin
            cnt <= 16'h0000;
            pol <= ~pol;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end

    // Sequence index runs only while info 1 goes out, so each burst starts aligned
    always_ff @(posedge clk) begin
        if (srst || tx_info != stl1_pkg::TX_INFO1) begin
            bit_idx <= 3'h0;
            line_bit <= 1'b0;
        end else begin
            bit_idx <= bit_idx + 3'h1;
            line_bit <= next_line_bit;
        end
    end

    // Single pulse mode fires only at the start of each half period
    always_ff @(posedge clk) begin
        if (srst) begin
            pulse_pos <= 1'b0;
            pulse_neg <= 1'b0;
        end else begin
            pulse_pos <= (is_scp && !pol) || (is_ssp && !pol && cnt == 16'h0000);
            pulse_neg <= (is_scp && pol) || (is_ssp && pol && cnt == 16'h0000);
        end
    end
endmodule : stl1_pulse_gen

//--- core/stl1_top.sv
// Layer-1 activation state machine with register port and clock output
//
// Chosen here: the register offsets and the strobed register port.
module stl1_top #(
    parameter int STOP_CYC = stl1_pkg::CLK_STOP_CYC
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic [3:0] CI_CMD_IN,
    output logic [3:0] CI_IND_OUT,
    input wire stl1_pkg::stl1_rx_s LINE_RX,
    output stl1_pkg::stl1_txinfo_e TX_INFO,
    output logic TX_BIT,
    output logic TX_PULSE_POS,
    output logic TX_PULSE_NEG,
    output logic LOOP_BACK,
    output logic USER_TO_BUS,
    output logic USER_TO_LINE,
    output logic ANALOG_PWRDN,
    output logic CLOCKS_RUN,
    output logic CI_CHANGE,
    output logic OSC_CLK_OUT
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    stl1_pkg::stl1_rx_s rx_meta, rx;
    logic [3:0] cmd_meta, cmd_pin;

    // Two flops before any logic reads the line or bus command
    always_ff @(posedge CLK) begin
        rx_meta <= LINE_RX;
        rx <= rx_meta;
        cmd_meta <= CI_CMD_IN;
        cmd_pin <= cmd_meta;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] config_reg;
    logic [3:0] ci_tx;
    logic [3:0] sw_cmd;
    logic ci_int;
    logic pwr_dn;
    stl1_pkg::stl1_state_e state;
    logic [3:0] ind;

    wire sw_ctl = config_reg[stl1_pkg::CFG_SWCTL_BIT];
    wire clock_freeze_select = config_reg[stl1_pkg::CFG_CFS_BIT];
    wire tx_dis = config_reg[stl1_pkg::CFG_TXDIS_BIT];
    wire int_loop = config_reg[stl1_pkg::CFG_INTLOOP_BIT];
    wire wr_cfg = WR && ADDR == stl1_pkg::ADDR_CONFIG;
    wire wr_citx = WR && ADDR == stl1_pkg::ADDR_CI_TX;
    wire wr_swcmd = WR && ADDR == stl1_pkg::ADDR_SW_CMD;
    wire rd_int = RD && ADDR == stl1_pkg::ADDR_INT;

    // Register writes; transmit register reset to the reset command
    always_ff @(posedge CLK) begin
        if (SRST) begin
            config_reg <= stl1_pkg::CONFIG_RESET;
            ci_tx <= stl1_pkg::CI_TX_RESET;
            sw_cmd <= stl1_pkg::CI_TX_RESET;
        end else begin
            if (wr_cfg) config_reg <= WDATA;
            if (wr_citx) ci_tx <= WDATA[3:0];
            if (wr_swcmd) sw_cmd <= WDATA[3:0];
        end
    end

    // Command source: software register bypasses the bus channel
    wire [3:0] cmd = sw_ctl ? sw_cmd : (cmd_pin | ci_tx) & ci_tx_mask(cmd_pin, ci_tx);
    function automatic logic [3:0] ci_tx_mask(input logic [3:0] a, input logic [3:0] b);
        // Host register wins unless it still holds its reset value
        ci_tx_mask = (b == stl1_pkg::CI_TX_RESET) ? a : b;
        ci_tx_mask = ci_tx_mask | ~(a | b);
    endfunction : ci_tx_mask

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    function automatic logic is_uncond(input logic [3:0] c);
        is_uncond = (c == stl1_pkg::CMD_RES) || (c == stl1_pkg::CMD_SSP) ||
                    (c == stl1_pkg::CMD_SCP) || (c == stl1_pkg::CMD_ARL);
    endfunction : is_uncond
    function automatic logic is_actreq(input logic [3:0] c);
        is_actreq = (c == stl1_pkg::CMD_AR8) || (c == stl1_pkg::CMD_ACTIVATION_REQUEST_PRIO10);
    endfunction : is_actreq

    wire c_uncond = is_uncond(cmd);
    wire c_ar = is_actreq(cmd);
    wire c_di = (cmd == stl1_pkg::CMD_DI);
    wire c_tim = (cmd == stl1_pkg::CMD_TIM);
    wire rx_other = !rx.info0 && !rx.info2 && !rx.info4;

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    stl1_pkg::stl1_state_e next_state;
    always_comb begin
        next_state = state;
        if (c_uncond) begin
            // Unconditional commands override every other condition
            unique case (cmd)
                stl1_pkg::CMD_RES: next_state = stl1_pkg::ST_RESET;
                stl1_pkg::CMD_SSP: next_state = stl1_pkg::ST_TEST_SSP;
                stl1_pkg::CMD_SCP: next_state = stl1_pkg::ST_TEST_SCP;
                default: begin
                    if (state != stl1_pkg::ST_LOOP_ACT)
                        next_state = stl1_pkg::ST_LOOP_CLOSED;
                    if (state == stl1_pkg::ST_LOOP_CLOSED && rx.sync)
                        next_state = stl1_pkg::ST_LOOP_ACT;
                end
            endcase
        end else begin
            unique case (state)
                stl1_pkg::ST_RESET, stl1_pkg::ST_LOOP_CLOSED, stl1_pkg::ST_LOOP_ACT,
                stl1_pkg::ST_TEST_SSP, stl1_pkg::ST_TEST_SCP:
                    next_state = stl1_pkg::ST_F3_DEACT;
                stl1_pkg::ST_F3_DEACT: begin
                    if (rx.info4 && rx.sync) next_state = stl1_pkg::ST_F7_ACT;
                    else if (rx.info2 && rx.sync) next_state = stl1_pkg::ST_F6_SYNC;
                    else if (c_ar) next_state = stl1_pkg::ST_F4_PEND_ACT;
                    else if (c_tim) next_state = stl1_pkg::ST_F3_PWRUP;
                end
                stl1_pkg::ST_F3_PEND_DEACT: begin
                    // Activation requests ignored here
                    if (c_di) next_state = stl1_pkg::ST_F3_DEACT;
                end
                stl1_pkg::ST_F3_PWRUP, stl1_pkg::ST_F4_PEND_ACT, stl1_pkg::ST_F5_UNSYNC: begin
                    if (c_di) next_state = stl1_pkg::ST_F3_DEACT;
                    else if (rx.info2 && rx.sync) next_state = stl1_pkg::ST_F6_SYNC;
                    else if (rx.info4 && rx.sync) next_state = stl1_pkg::ST_F7_ACT;
                    else if (rx_other) next_state = stl1_pkg::ST_F5_UNSYNC;
                    else if (state == stl1_pkg::ST_F3_PWRUP && c_ar)
                        next_state = stl1_pkg::ST_F4_PEND_ACT;
                end
                stl1_pkg::ST_F6_SYNC, stl1_pkg::ST_F7_ACT, stl1_pkg::ST_F8_LOST: begin
                    if (rx.info0) next_state = stl1_pkg::ST_F3_PEND_DEACT;
                    else if (!rx.sync) next_state = stl1_pkg::ST_F8_LOST;
                    else if (rx.info4) next_state = stl1_pkg::ST_F7_ACT;
                    else if (rx.info2) next_state = stl1_pkg::ST_F6_SYNC;
                end
                default: next_state = stl1_pkg::ST_RESET;
            endcase
        end
    end

    // State register evaluated each clock
    always_ff @(posedge CLK) begin
        if (SRST) state <= stl1_pkg::ST_RESET;
        else state <= next_state;
    end

    // ------------------------------------------------------------
    // Clock stop timer in F3 deactivated
    // ------------------------------------------------------------
    logic [15:0] stop_cnt;
    wire stop_arm = state == stl1_pkg::ST_F3_DEACT && rx.info0 && !clock_freeze_select;
    wire stop_done = stop_cnt >= 16'(STOP_CYC);

    // Counts from entry; restarts whenever the condition drops
    always_ff @(posedge CLK) begin
        if (SRST || !stop_arm) stop_cnt <= 16'h0000;
        else if (!stop_done) stop_cnt <= stop_cnt + 16'h0001;
    end

    // Power down bit; leaving F3 deactivated wakes the analog part
    always_ff @(posedge CLK) begin
        if (SRST) pwr_dn <= 1'b0;
        else pwr_dn <= stop_arm && stop_done;
    end

    // ------------------------------------------------------------
    // Indications and transmitted infos
    // ------------------------------------------------------------
    logic [3:0] next_ind;
    stl1_pkg::stl1_txinfo_e next_tx;
    wire activation_request_prio10_held = (cmd == stl1_pkg::CMD_ACTIVATION_REQUEST_PRIO10);
    always_comb begin
        next_ind = stl1_pkg::IND_DR;
        next_tx = stl1_pkg::TX_INFO0;
        unique case (state)
            stl1_pkg::ST_RESET: next_ind = stl1_pkg::IND_RES;
            stl1_pkg::ST_F3_DEACT: next_ind = stl1_pkg::IND_DC;
            stl1_pkg::ST_F3_PWRUP: next_ind = stl1_pkg::IND_PU;
            stl1_pkg::ST_F3_PEND_DEACT: next_ind = stl1_pkg::IND_DR;
            stl1_pkg::ST_F4_PEND_ACT: begin
                next_ind = stl1_pkg::IND_PU;
                next_tx = stl1_pkg::TX_INFO1;
            end
            stl1_pkg::ST_F5_UNSYNC: next_ind = stl1_pkg::IND_RSY;
            stl1_pkg::ST_F6_SYNC: begin
                next_ind = stl1_pkg::IND_AR;
                next_tx = stl1_pkg::TX_INFO3;
            end
            stl1_pkg::ST_F7_ACT: begin
                next_ind = activation_request_prio10_held ? stl1_pkg::IND_AI10 : stl1_pkg::IND_AI8;
                next_tx = stl1_pkg::TX_INFO3;
            end
            stl1_pkg::ST_F8_LOST: next_ind = stl1_pkg::IND_RSY;
            stl1_pkg::ST_LOOP_CLOSED: begin
                next_ind = stl1_pkg::IND_ARL;
                next_tx = stl1_pkg::TX_INFO3;
            end
            stl1_pkg::ST_LOOP_ACT: begin
                // Internal loop reports resync if the line is awake
                next_ind = (int_loop && rx.awake) ? stl1_pkg::IND_RSY
                                                  : stl1_pkg::IND_AIL;
                next_tx = stl1_pkg::TX_INFO3;
            end
            stl1_pkg::ST_TEST_SSP: begin
                next_ind = stl1_pkg::IND_TMA;
                next_tx = stl1_pkg::TX_TEST1;
            end
            stl1_pkg::ST_TEST_SCP: begin
                next_ind = stl1_pkg::IND_TMA;
                next_tx = stl1_pkg::TX_TEST2;
            end
            default: next_ind = stl1_pkg::IND_RES;
        endcase
        // Transmit disable keeps an internal loop off the wire
        if (tx_dis) next_tx = stl1_pkg::TX_INFO0;
    end

    // Indication posting; change flag set wins over read clear
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ind <= stl1_pkg::IND_RES;
            ci_int <= 1'b0;
        end else begin
            ind <= next_ind;
            if (next_ind != ind) ci_int <= 1'b1;
            else if (rd_int) ci_int <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Line pattern generator
    // ------------------------------------------------------------
    logic gen_bit, gen_pos, gen_neg;
    stl1_pulse_gen u_gen (
        .clk(CLK),
        .srst(SRST),
        .tx_info(next_tx),
        .line_bit(gen_bit),
        .pulse_pos(gen_pos),
        .pulse_neg(gen_neg)
    );

    // ------------------------------------------------------------
    // Outputs, all registered
    // ------------------------------------------------------------
    localparam int OSC_W = stl1_pkg::OSC_DIV;
    logic [OSC_W-1:0] osc_div;
    logic [7:0] next_rdata;
    always_comb begin
        unique case (ADDR)
            stl1_pkg::ADDR_CONFIG: next_rdata = config_reg;
            stl1_pkg::ADDR_CI_TX: next_rdata = {4'h0, ci_tx};
            stl1_pkg::ADDR_CI_RX: next_rdata = {4'h0, ind};
            stl1_pkg::ADDR_SW_CMD: next_rdata = {4'h0, sw_cmd};
            stl1_pkg::ADDR_STATUS: next_rdata = {rx.sync, pwr_dn, 2'h0, state};
            stl1_pkg::ADDR_INT: next_rdata = {7'h00, ci_int};
            default: next_rdata = 8'h00;
        endcase
    end

    // Output flops; the clock out is a divided copy of the core clock
    always_ff @(posedge CLK) begin
        if (SRST) begin
            RDATA <= 8'h00;
            CI_IND_OUT <= stl1_pkg::IND_RES;
            TX_INFO <= stl1_pkg::TX_INFO0;
            TX_BIT <= 1'b0;
            TX_PULSE_POS <= 1'b0;
            TX_PULSE_NEG <= 1'b0;
            LOOP_BACK <= 1'b0;
            USER_TO_BUS <= 1'b0;
            USER_TO_LINE <= 1'b0;
            ANALOG_PWRDN <= 1'b0;
            CLOCKS_RUN <= 1'b1;
            CI_CHANGE <= 1'b0;
            OSC_CLK_OUT <= 1'b0;
            osc_div <= '0;
        end else begin
            RDATA <= RD ? next_rdata : 8'h00;
            CI_IND_OUT <= sw_ctl ? 4'h0 : next_ind;
            TX_INFO <= next_tx;
            TX_BIT <= gen_bit;
            TX_PULSE_POS <= gen_pos;
            TX_PULSE_NEG <= gen_neg;
            LOOP_BACK <= state == stl1_pkg::ST_LOOP_CLOSED ||
                         state == stl1_pkg::ST_LOOP_ACT;
            USER_TO_BUS <= state == stl1_pkg::ST_F7_ACT;
            USER_TO_LINE <= state == stl1_pkg::ST_F7_ACT && c_ar && rx.sync;
            ANALOG_PWRDN <= pwr_dn;
            CLOCKS_RUN <= !pwr_dn;
            CI_CHANGE <= ci_int;
            osc_div <= osc_div + 1'b1;
            OSC_CLK_OUT <= pwr_dn ? 1'b0 : osc_div[0];
        end
    end
endmodule : stl1_top

//--- bench/stl1_monitor.sv
// Port checker for the layer-1 activation block
module stl1_monitor #(
    parameter int STOP_CYC = 20
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire stl1_pkg::stl1_txinfo_e TX_INFO,
    input wire logic TX_BIT,
    input wire logic TX_PULSE_POS,
    input wire logic TX_PULSE_NEG,
    input wire logic LOOP_BACK,
    input wire logic USER_TO_BUS,
    input wire logic USER_TO_LINE,
    input wire logic ANALOG_PWRDN,
    input wire logic CLOCKS_RUN,
    input wire logic [3:0] CI_IND_OUT,
    input wire logic OSC_CLK_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] gap;
    logic [15:0] dc_cnt;
    logic seen;
    default clocking dck @(posedge CLK); endclocking
    default disable iff (SRST);
    // Pulse spacing within one mode; the first gap of a mode is never judged
    always_ff @(posedge CLK) begin
        gap <= (SRST || $rose(TX_PULSE_POS)) ? 16'h0001 : gap + 16'h0001;
        seen <= (SRST || TX_INFO != $past(TX_INFO)) ? 1'b0 : seen | $rose(TX_PULSE_POS);
        dc_cnt <= (CI_IND_OUT == stl1_pkg::IND_DC) ? dc_cnt + 16'h0001 : 16'h0000;
    end
    osc_pd_low_a: assert property (ANALOG_PWRDN && $past(ANALOG_PWRDN) |-> !OSC_CLK_OUT)
        else $error("clock output high in power down");
    osc_square_a: assert property (!ANALOG_PWRDN && !$past(ANALOG_PWRDN) &&
        !$past(ANALOG_PWRDN, 2) && !$past(SRST) && !$past(SRST, 2) && !$past(SRST, 3)
        |-> OSC_CLK_OUT == $past(OSC_CLK_OUT, 2) && OSC_CLK_OUT != $past(OSC_CLK_OUT))
        else $error("clock output not a half-rate square");
    info1_period_a: assert property (TX_INFO == stl1_pkg::TX_INFO1 &&
        $past(TX_INFO, 9) == stl1_pkg::TX_INFO1 |-> TX_BIT == $past(TX_BIT, 8))
        else $error("info 1 pattern not eight bits long");
    idle_quiet_a: assert property (TX_INFO == stl1_pkg::TX_INFO0 &&
        $past(TX_INFO) == stl1_pkg::TX_INFO0 |-> !(TX_PULSE_POS || TX_PULSE_NEG))
        else $error("pulses while line is silent");
    scp_period_a: assert property ($rose(TX_PULSE_POS) && seen &&
        TX_INFO == stl1_pkg::TX_TEST2 |-> gap == 16'(2 * stl1_pkg::SCP_HALF_CYC))
        else $error("continuous pulse period wrong");
    ssp_period_a: assert property ($rose(TX_PULSE_POS) && seen &&
        TX_INFO == stl1_pkg::TX_TEST1 |-> gap == 16'(2 * stl1_pkg::SSP_HALF_CYC))
        else $error("single pulse period wrong");
    clock_stop_a: assert property ($fell(CLOCKS_RUN) |->
        dc_cnt >= STOP_CYC - 2 && dc_cnt <= STOP_CYC + 2)
        else $error("clocks stopped at wrong time");
    line_pass_a: assert property (USER_TO_LINE |-> USER_TO_BUS)
        else $error("line path open outside activation");
    loop_info3_a: assert property (LOOP_BACK |-> TX_INFO == stl1_pkg::TX_INFO3)
        else $error("loop without info 3");
    stop_seen_c: cover property ($fell(CLOCKS_RUN));
    line_pass_c: cover property (USER_TO_LINE);
    loop_act_c: cover property (LOOP_BACK && CI_IND_OUT == stl1_pkg::IND_AIL);
endmodule : stl1_monitor
bind stl1_top stl1_monitor #(.STOP_CYC(STOP_CYC)) i_mon (.*);

//--- bench/stl1_nt_model.sv
// Network termination model facing the block across the line
module stl1_nt_model (
    input wire logic clk,
    input wire logic [1:0] mode,
    input wire stl1_pkg::stl1_txinfo_e tx_info,
    input wire logic loop_back,
    output stl1_pkg::stl1_rx_s rx
);
    timeunit 1ns;
    timeprecision 1ns;
    // Modes: 0 silent, 1 answering, 2 framing lost, 3 foreign signal
    always_ff @(posedge clk) begin
        rx.info0 <= (mode == 2'h0) && !loop_back;
        rx.info2 <= (mode == 2'h1) && !loop_back && tx_info != stl1_pkg::TX_INFO3;
        rx.info4 <= !loop_back && (mode == 2'h2 ||
            (mode == 2'h1 && tx_info == stl1_pkg::TX_INFO3));
        rx.sync <= loop_back ? mode != 2'h0 : mode == 2'h1;
        rx.awake <= mode != 2'h0;
    end
endmodule : stl1_nt_model

//--- bench/stl1_top_bench.sv
// Self-checking bench for the layer-1 activation block
module stl1_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int STOP = 20;
    logic CLK = 1'b0, SRST = 1'b1, WR = 1'b0, RD = 1'b0;
    logic [3:0] ADDR = 4'h0, CI_CMD_IN = 4'h1, CI_IND_OUT;
    logic [7:0] WDATA = 8'h00, RDATA, d;
    logic [1:0] mode = 2'h0;
    logic TX_BIT, TX_PULSE_POS, TX_PULSE_NEG, LOOP_BACK, USER_TO_BUS, USER_TO_LINE;
    logic ANALOG_PWRDN, CLOCKS_RUN, CI_CHANGE, OSC_CLK_OUT;
    stl1_pkg::stl1_rx_s LINE_RX;
    stl1_pkg::stl1_txinfo_e TX_INFO;
    logic [16:0] seed = 17'h12F74;
    int error_cnt = 0, n_tests = 0, n, k;
    logic [3:0] ucmd [4] = '{4'h1, 4'h2, 4'h3, 4'hA};
    // Free-running 10 MHz clock
    always #50 CLK = ~CLK;
    stl1_top #(.STOP_CYC(STOP)) i_dut (.*);
    stl1_nt_model i_nt (.clk(CLK), .mode(mode), .tx_info(TX_INFO), .loop_back(LOOP_BACK),
        .rx(LINE_RX));
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr
    // Indication and line info expected after a command
    function automatic logic [6:0] exp_of(input logic [3:0] c);
        case (c)
            4'h0: return {stl1_pkg::IND_PU, stl1_pkg::TX_INFO0};
            4'h1: return {stl1_pkg::IND_RES, stl1_pkg::TX_INFO0};
            4'h2: return {stl1_pkg::IND_TMA, stl1_pkg::TX_TEST1};
            4'h3: return {stl1_pkg::IND_TMA, stl1_pkg::TX_TEST2};
            4'hF: return {stl1_pkg::IND_DC, stl1_pkg::TX_INFO0};
            default: return {stl1_pkg::IND_ARL, stl1_pkg::TX_INFO3};
        endcase
    endfunction : exp_of
    // True when the byte is some rotation of the info 1 pattern
    function automatic logic rot_ok(input logic [7:0] b);
        logic [7:0] p;
        p = stl1_pkg::INFO1_PATTERN;
        rot_ok = 1'b0;
        for (int i = 0; i < 8; i++) begin
            rot_ok = rot_ok | (b === p);
            p = {p[6:0], p[7]};
        end
    endfunction : rot_ok
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask : chk
    task automatic tick(input int c);
        repeat (c) @(posedge CLK);
    endtask : tick
    // Command pin and line mode change together; latency is sync plus state plus output
    task automatic step(input logic [3:0] c, input logic [1:0] m);
        @(posedge CLK);
        CI_CMD_IN <= c;
        mode <= m;
        tick(8);
        #1;
    endtask : step
    task automatic cmd(input logic [3:0] c);
        step(c, mode);
        chk("ind", 8'(exp_of(c) >> 3), 8'(CI_IND_OUT));
        chk("info", 8'(exp_of(c) & 7'h07), 8'(TX_INFO));
    endtask : cmd
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask : rd
    task automatic summarize;
        $display("Checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    // Main sequence: registers, deactivation, activation, unconditional states
    initial begin
        tick(12);
        SRST <= 1'b0;
        rd(stl1_pkg::ADDR_CONFIG);
        chk("cfg", stl1_pkg::CONFIG_RESET, d);
        rd(stl1_pkg::ADDR_CI_TX);
        chk("citx", 8'(stl1_pkg::CI_TX_RESET), d);
        seed = lfsr(seed);
        wr(4'hF, seed[7:0]);
        rd(4'hF);
        chk("unmapped", 8'h00, d);
        @(posedge CLK);
        CI_CMD_IN <= stl1_pkg::CMD_DI;
        #1;
        for (n = 0; n < 200 && CLOCKS_RUN !== 1'b0; n++) #100;
        if (n == 200) begin
            error_cnt++;
            summarize();
        end
        chk("stop_at", 8'h01, 8'(n >= STOP && n <= STOP + 8));
        chk("pwrdn", 8'h01, 8'(ANALOG_PWRDN));
        chk("osc", 8'h00, 8'(OSC_CLK_OUT));
        chk("chg", 8'h01, 8'(CI_CHANGE));
        rd(stl1_pkg::ADDR_CI_RX);
        chk("cirx", 8'(stl1_pkg::IND_DC), 8'(d[3:0]));
        rd(stl1_pkg::ADDR_INT);
        chk("chg_rd", 8'h01, 8'(d[0]));
        tick(1);
        #1 chk("chg_clr", 8'h00, 8'(CI_CHANGE));
        cmd(stl1_pkg::CMD_TIM);
        chk("clk_on", 8'h01, 8'(CLOCKS_RUN));
        cmd(stl1_pkg::CMD_DI);
        step(stl1_pkg::CMD_AR8, 2'h0);
        chk("f4", 8'(stl1_pkg::TX_INFO1), 8'(TX_INFO));
        for (k = 0; k < 8; k++) #100 d = {d[6:0], TX_BIT};
        chk("info1", 8'h01, 8'(rot_ok(d)));
        step(stl1_pkg::CMD_AR8, 2'h3);
        chk("f5", 8'(stl1_pkg::TX_INFO0), 8'(TX_INFO));
        step(stl1_pkg::CMD_AR8, 2'h1);
        #800;
        chk("f7", 8'(stl1_pkg::IND_AI8), 8'(CI_IND_OUT));
        chk("to_line", 8'h03, {6'h00, USER_TO_BUS, USER_TO_LINE});
        step(stl1_pkg::CMD_TIM, 2'h1);
        chk("line_off", 8'h02, {6'h00, USER_TO_BUS, USER_TO_LINE});
        step(stl1_pkg::CMD_ACTIVATION_REQUEST_PRIO10, 2'h2);
        chk("f8", 8'h00, 8'(USER_TO_BUS));
        step(stl1_pkg::CMD_ACTIVATION_REQUEST_PRIO10, 2'h0);
        chk("pend", 8'(stl1_pkg::IND_DR), 8'(CI_IND_OUT));
        chk("pend_tx", 8'(stl1_pkg::TX_INFO0), 8'(TX_INFO));
        cmd(stl1_pkg::CMD_DI);
        for (k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            cmd(ucmd[seed[1:0]]);
            cmd(stl1_pkg::CMD_RES);
        end
        cmd(stl1_pkg::CMD_SSP);
        tick(11000);
        cmd(stl1_pkg::CMD_RES);
        cmd(stl1_pkg::CMD_SCP);
        tick(400);
        cmd(stl1_pkg::CMD_ARL);
        step(stl1_pkg::CMD_ARL, 2'h1);
        chk("ail", 8'(stl1_pkg::IND_AIL), 8'(CI_IND_OUT));
        wr(stl1_pkg::ADDR_CI_TX, 8'(stl1_pkg::CMD_SSP));
        tick(2);
        rd(stl1_pkg::ADDR_CI_RX);
        chk("cix", 8'(stl1_pkg::IND_TMA), d);
        wr(stl1_pkg::ADDR_CONFIG, 8'h01);
        wr(stl1_pkg::ADDR_SW_CMD, 8'(stl1_pkg::CMD_SCP));
        tick(4);
        rd(stl1_pkg::ADDR_STATUS);
        chk("sw", 8'(stl1_pkg::ST_TEST_SCP), {CI_IND_OUT, d[3:0]});
        summarize();
    end
endmodule : stl1_top_bench
